// ---- rtl/qei_defines.vh ----
// Register offsets, control fields and reset values for the encoder block
`ifndef QEI_DEFINES_VH
`define QEI_DEFINES_VH
`define QEI_OFS_CTL     4'h0
`define QEI_OFS_STAT    4'h1
`define QEI_OFS_POS     4'h2
`define QEI_OFS_MAXPOS  4'h3
`define QEI_OFS_LOAD    4'h4
`define QEI_OFS_TIME    4'h5
`define QEI_OFS_COUNT   4'h6
`define QEI_OFS_SPEED   4'h7
`define QEI_OFS_INTEN   4'h8
`define QEI_OFS_RIS     4'h9
`define QEI_OFS_ISC     4'ha
`define QEI_CTL_EN      0
`define QEI_CTL_SWAP    1
`define QEI_CTL_SIG     2
`define QEI_CTL_CAP     3
`define QEI_CTL_RES     4
`define QEI_CTL_VEL     5
`define QEI_CTL_DIV_LO  6
`define QEI_CTL_DIV_HI  8
`define QEI_CTL_PHASE_A_INVERT    9
`define QEI_CTL_PHASE_B_INVERT    10
`define QEI_CTL_INDEX_INVERT    11
`define QEI_CTL_STALL   12
`define QEI_CTL_W       13
`define QEI_INT_INDEX   0
`define QEI_INT_TIMER   1
`define QEI_INT_DIR     2
`define QEI_INT_ERR     3
`define QEI_INT_W       4
`define QEI_RST_WORD    32'h0000_0000
`endif

// ---- rtl/qei_core.v ----
// Quadrature encoder interface with Avalon-MM register slave
`timescale 1ns/10ps
// How it works
// R1: Encoder phase toggle rate stays at or below a quarter of mclk.
// R2: Velocity capture runs only while enable and velocity enable are both set.
// R3: Swap bit exchanges phase A and B before decoding.
// R4: Mode zero decodes quadrature phases using their edge order.
// R5: Mode one uses A as step clock and B as direction level.
// R6: Capture select counts A edges only, or both A and B edges.
// R7: Phase A leading phase B increments position.
// R8: Phase B leading phase A decrements position.
// R9: Two edges on one phase with none between flags direction change.
// R10: Reset select one clears position on index.
// R11: Backward step from zero wraps to the maximum.
// R12: Reset select zero wraps at maximum and ignores index.
// R13: Velocity counts the same edges that move the position.
// R14: Period end copies accumulator to result, then clears accumulator.
// R15: Timer counts down, flags expiry at zero, reloads and continues.
// R16: Interrupts on phase error, direction change, index and timer.
// R17: Each source has mask, raw status, masked status and a clear.
// R18: Predivider divides counted edges by two to the field value.
// R19: Control word bits 0 to 5 as enable, swap, mode, cap, reset, vel.
// R20: Invert bits for A, B, index; stall bit freezes position and accumulator while halted; timer reloads.
// R21: In mode zero both phases changing together flag an error; position holds.
// R22: Phase and index inputs pass two flip-flops before edge logic.
module qei_core #(
   parameter W = 32
) (
   input  wire          mclk,
   input  wire          rst,
   input  wire          phase_a_input,
   input  wire          phase_b_input,
   input  wire          index_input,
   input  wire          cpu_halt,
   input  wire [3:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output reg  [31:0]   avs_readdata,
   output wire          avs_waitrequest,
   output wire          irq
);
`include "qei_defines.vh"

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg  [`QEI_CTL_W-1:0] encoder_control_word;
reg  [W-1:0]          position;
reg  [W-1:0]          max_position_reg;
reg  [W-1:0]          velocity_period_load;
reg  [W-1:0]          velocity_timer;
reg  [W-1:0]          velocity_accum_reg;
reg  [W-1:0]          velocity_result_reg;
reg  [`QEI_INT_W-1:0] int_mask;
reg  [`QEI_INT_W-1:0] int_raw;
reg                   direction;
reg                   bus_ack;

wire enable_on   = encoder_control_word[`QEI_CTL_EN];
wire swap_on     = encoder_control_word[`QEI_CTL_SWAP];
wire signal_mode_select    = encoder_control_word[`QEI_CTL_SIG];
wire edge_capture_select   = encoder_control_word[`QEI_CTL_CAP];
wire position_reset_select = encoder_control_word[`QEI_CTL_RES];
wire velocity_capture_on   = encoder_control_word[`QEI_CTL_VEL];
wire [2:0] velocity_predivide =
   encoder_control_word[`QEI_CTL_DIV_HI:`QEI_CTL_DIV_LO];
wire phase_a_invert = encoder_control_word[`QEI_CTL_PHASE_A_INVERT];
wire phase_b_invert = encoder_control_word[`QEI_CTL_PHASE_B_INVERT];
wire index_invert   = encoder_control_word[`QEI_CTL_INDEX_INVERT];
wire halt_freeze    = encoder_control_word[`QEI_CTL_STALL];

// ---------------------------------------------------------------
// Input synchronisers
// ---------------------------------------------------------------
// First stage feeds only the second stage
reg [2:0] sync1;
reg [2:0] sync2;
reg [2:0] prev;
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
   end else begin
      sync1 <= {index_input, phase_b_input, phase_a_input}; // R22
      sync2 <= sync1; // R22
   end
end

wire run = enable_on & ~(halt_freeze & cpu_halt); // R20
wire a_inv = sync2[0] ^ phase_a_invert; // R20
wire b_inv = sync2[1] ^ phase_b_invert; // R20
wire i_inv = sync2[2] ^ index_invert; // R20
wire pa = swap_on ? b_inv : a_inv; // R3
wire pb = swap_on ? a_inv : b_inv; // R3

// prev holds the conditioned levels of the previous cycle
always @(posedge mclk or posedge rst) begin
   if (rst)
      prev <= 3'h0;
   else
      prev <= {i_inv, pb, pa};
end

wire a_edge = pa ^ prev[0];
wire b_edge = pb ^ prev[1];
wire idx_rise = i_inv & ~prev[2];

// ---------------------------------------------------------------
// Edge decode
// ---------------------------------------------------------------
reg last_phase; // Phase of last edge seen: 0 = A, 1 = B
reg step;
reg step_up;
reg phase_err;
reg edge_seen;
always @* begin
   step = 1'b0;
   step_up = 1'b0;
   phase_err = 1'b0;
   if (signal_mode_select) begin
      step = a_edge & pa; // R5
      step_up = ~pb; // R5
   end else if (a_edge & b_edge) begin
      phase_err = 1'b1; // R21
   end else if (a_edge) begin
      step = 1'b1; // R6
      step_up = (pa != pb); // R4 R7
   end else if (b_edge) begin
      step = edge_capture_select; // R6
      step_up = (pa == pb); // R4 R8
   end
end

// Same phase edged twice in a row means the shaft turned back
// No reversal can be judged before a first edge
wire dir_flip = ~signal_mode_select & ~phase_err & edge_seen &
   ((a_edge & ~last_phase) | (b_edge & last_phase)); // R9
// Direction holds 1 while travelling backward
wire clk_dir_flip = signal_mode_select & step & (step_up == direction); // R9

always @(posedge mclk or posedge rst) begin
   if (rst) begin
      last_phase <= 1'b0;
      edge_seen <= 1'b0;
      direction <= 1'b0;
   end else if (run) begin
      if (!signal_mode_select && a_edge != b_edge) begin
         last_phase <= b_edge; // R9
         edge_seen <= 1'b1;
      end
      if (step)
         direction <= ~step_up;
   end
end

// ---------------------------------------------------------------
// Position integrator
// ---------------------------------------------------------------
reg  [W-1:0] next_position;
always @* begin
   next_position = position;
   if (position_reset_select && idx_rise) begin
      next_position = {W{1'b0}}; // R10
   end else if (step && step_up) begin
      if (position >= max_position_reg)
         next_position = {W{1'b0}}; // R12
      else
         next_position = position + 1'b1; // R7
   end else if (step) begin
      if (position == {W{1'b0}})
         next_position = max_position_reg; // R11
      else
         next_position = position - 1'b1; // R8
   end
end

// ---------------------------------------------------------------
// Velocity capture
// ---------------------------------------------------------------
reg  [7:0] prediv_cnt;
wire vel_run = run & velocity_capture_on; // R2
wire [7:0] prediv_mask = (8'h01 << velocity_predivide) - 8'h01; // R18
wire prediv_out = step & ((prediv_cnt & prediv_mask) == prediv_mask);
wire period_end = vel_run && (velocity_timer == {W{1'b0}}); // R15

// ---------------------------------------------------------------
// Avalon-MM slave, one wait cycle per access
// ---------------------------------------------------------------
wire access = (avs_read | avs_write) & ~bus_ack;
assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
wire wr_now = avs_write & bus_ack;
wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

function [31:0] merge;
   input [31:0] old;
   input [31:0] wd;
   input [31:0] m;
   begin
      merge = (old & ~m) | (wd & m);
   end
endfunction

wire [31:0] ctl_wide = {{(32-`QEI_CTL_W){1'b0}}, encoder_control_word};
wire [31:0] ctl_new  = merge(ctl_wide, avs_writedata, be_mask);
wire [`QEI_INT_W-1:0] events = {phase_err | 1'b0,
   dir_flip | clk_dir_flip, period_end, idx_rise} & {`QEI_INT_W{run}}; // R16
wire [`QEI_INT_W-1:0] clr_bits = (wr_now && avs_address == `QEI_OFS_ISC) ?
   avs_writedata[`QEI_INT_W-1:0] : {`QEI_INT_W{1'b0}};

// ---------------------------------------------------------------
// Bus acknowledge
// ---------------------------------------------------------------
always @(posedge mclk or posedge rst) begin
   if (rst)
      bus_ack <= 1'b0;
   else
      bus_ack <= access;
end

// ---------------------------------------------------------------
// Interrupt status and mask
// ---------------------------------------------------------------
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      int_mask <= {`QEI_INT_W{1'b0}};
      int_raw <= {`QEI_INT_W{1'b0}};
   end else begin
      // Set wins over a clear in the same cycle
      int_raw <= (int_raw & ~clr_bits) | events; // R17
      if (wr_now && avs_address == `QEI_OFS_INTEN)
         int_mask <= avs_writedata[`QEI_INT_W-1:0]; // R17
   end
end

// ---------------------------------------------------------------
// Position register
// ---------------------------------------------------------------
// A software write beats a step landing in the same cycle
always @(posedge mclk or posedge rst) begin
   if (rst)
      position <= {W{1'b0}};
   else if (wr_now && avs_address == `QEI_OFS_POS)
      position <= merge(position, avs_writedata, be_mask);
   else if (run)
      position <= next_position;
end

// ---------------------------------------------------------------
// Velocity timer and accumulator
// ---------------------------------------------------------------
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      velocity_timer <= {W{1'b0}};
      velocity_accum_reg <= {W{1'b0}};
      velocity_result_reg <= {W{1'b0}};
      prediv_cnt <= 8'h00;
   end else if (vel_run) begin
      if (period_end) begin
         velocity_result_reg <= velocity_accum_reg
            + {{(W-1){1'b0}}, prediv_out}; // R14
         velocity_accum_reg <= {W{1'b0}}; // R14
         velocity_timer <= velocity_period_load; // R15
      end else begin
         velocity_timer <= velocity_timer - 1'b1; // R15
         if (prediv_out)
            velocity_accum_reg <= velocity_accum_reg + 1'b1; // R13
      end
      if (step)
         prediv_cnt <= prediv_cnt + 8'h01; // R18
   end else begin
      // Idle timer tracks the load so a new period starts full
      velocity_timer <= velocity_period_load;
      prediv_cnt <= 8'h00;
   end
end

// ---------------------------------------------------------------
// Configuration registers
// ---------------------------------------------------------------
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      encoder_control_word <= {`QEI_CTL_W{1'b0}};
      max_position_reg <= {W{1'b0}};
      velocity_period_load <= {W{1'b0}};
   end else if (wr_now) begin
      case (avs_address)
         `QEI_OFS_CTL: begin
            encoder_control_word <= ctl_new[`QEI_CTL_W-1:0]; // R19
            // Velocity needs the integrator on
            if (!ctl_new[`QEI_CTL_EN])
               encoder_control_word[`QEI_CTL_VEL] <= 1'b0; // R2
         end
         `QEI_OFS_MAXPOS:
            max_position_reg <= merge(max_position_reg,
                                      avs_writedata, be_mask); // R11
         `QEI_OFS_LOAD:
            velocity_period_load <= merge(velocity_period_load,
                                          avs_writedata, be_mask);
         default: ;
      endcase
   end
end

// ---------------------------------------------------------------
// Read mux
// ---------------------------------------------------------------
// Data is taken in the wait cycle and held until the next read
wire [31:0] stat_word = {30'h0, direction, int_raw[`QEI_INT_ERR]};
reg  [31:0] next_readdata;
always @* begin
   next_readdata = avs_readdata;
   if (avs_read && !bus_ack) begin
      case (avs_address)
         `QEI_OFS_CTL:    next_readdata = ctl_wide;
         `QEI_OFS_STAT:   next_readdata = stat_word;
         `QEI_OFS_POS:    next_readdata = position;
         `QEI_OFS_MAXPOS: next_readdata = max_position_reg;
         `QEI_OFS_LOAD:   next_readdata = velocity_period_load;
         `QEI_OFS_TIME:   next_readdata = velocity_timer;
         `QEI_OFS_COUNT:  next_readdata = velocity_accum_reg;
         `QEI_OFS_SPEED:  next_readdata = velocity_result_reg;
         `QEI_OFS_INTEN:  next_readdata = {28'h0, int_mask};
         `QEI_OFS_RIS:    next_readdata = {28'h0, int_raw}; // R17
         `QEI_OFS_ISC:    next_readdata = {28'h0, int_raw & int_mask}; // R17
         default:         next_readdata = 32'h0000_0000;
      endcase
   end
end

always @(posedge mclk or posedge rst) begin
   if (rst)
      avs_readdata <= `QEI_RST_WORD;
   else
      avs_readdata <= next_readdata;
end

assign irq = |(int_raw & int_mask); // R16

endmodule // qei_core

// ---- dv/qei_enc_model.sv ----
// Behavioural two-channel encoder with index, driving the phase pins
`timescale 1ns/10ps
module qei_enc_model (
   input  wire mclk,
   output reg  phase_a,
   output reg  phase_b,
   output reg  index_pulse
);
   initial begin
      phase_a = 1'b0;
      phase_b = 1'b0;
      index_pulse = 1'b0;
   end
   // Six cycles per level keeps toggles well under a quarter of mclk
   task mv(input logic a, b, i);
      @(posedge mclk);
      phase_a <= a;
      phase_b <= b;
      index_pulse <= i;
      repeat (5) @(posedge mclk);
   endtask
   // One gray step; forward lets A lead, backward lets B lead
   task step(input logic fw);
      if ((phase_a == phase_b) == fw) mv(~phase_a, phase_b, 1'b0);
      else mv(phase_a, ~phase_b, 1'b0);
   endtask
endmodule // qei_enc_model

// ---- dv/qei_core_assertions.sv ----
// Concurrent checks on the register port of the encoder block
`timescale 1ns/10ps
module qei_core_assertions (
   input wire        mclk,
   input wire        rst,
   input wire        phase_a_input,
   input wire        phase_b_input,
   input wire        index_input,
   input wire        cpu_halt,
   input wire [3:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        irq
);
   // --------------------------------------------------
   // Shadows of the control, maximum position, period load and interrupt mask registers
   // --------------------------------------------------
   wire        wdone = avs_write && !avs_waitrequest;
   wire        rdone = avs_read && !avs_waitrequest;
   wire [31:0] bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   reg  [31:0] ctl, mx, ld, ien;
   wire [31:0] cm = ((ctl & ~bm) | (avs_writedata & bm)) & 32'h1fff;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl <= 32'h0;
         mx <= 32'h0;
         ld <= 32'h0;
         ien <= 32'h0;
      end else if (wdone) begin
         case (avs_address)
            4'h0: ctl <= cm[0] ? cm : (cm & 32'h1fdf);
            4'h3: mx <= (mx & ~bm) | (avs_writedata & bm);
            4'h4: ld <= (ld & ~bm) | (avs_writedata & bm);
            4'h8: ien <= avs_writedata & 32'hf;
            default: ;
         endcase
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_wait_first: assert property (
      $rose(avs_read | avs_write) |-> avs_waitrequest)
      else $error("request answered without wait");
   a_wait_one: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait lasted over one cycle");
   a_irq_masked: assert property (irq |-> ien != 32'h0)
      else $error("interrupt with all sources masked");
   a_ctl_readback: assert property (
      rdone && avs_address == 4'h0 |-> avs_readdata == ctl)
      else $error("control word readback wrong");
   a_max_readback: assert property (
      rdone && avs_address == 4'h3 |-> avs_readdata == mx)
      else $error("maximum position readback wrong");
   a_load_readback: assert property (
      rdone && avs_address == 4'h4 |-> avs_readdata == ld)
      else $error("period load readback wrong");
   a_mask_readback: assert property (
      rdone && avs_address == 4'h8 |-> avs_readdata == ien)
      else $error("interrupt mask readback wrong");
   a_unmapped_zero: assert property (
      rdone && avs_address > 4'ha |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (rdone && avs_address == 4'h2);
   cover property (irq);
   cover property (wdone && avs_address == 4'ha);
endmodule // qei_core_assertions

bind qei_core qei_core_assertions u_chk (.mclk(mclk), .rst(rst),
   .phase_a_input(phase_a_input), .phase_b_input(phase_b_input),
   .index_input(index_input), .cpu_halt(cpu_halt),
   .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq(irq));

// ---- dv/testbench.sv ----
// Self-checking bench for the quadrature encoder block
`timescale 1ns/10ps
module testbench;
   reg         mclk = 1'b0;
   reg         rst = 1'b1;
   reg         cpu_halt = 1'b0;
   reg  [3:0]  adr = 4'h0;
   reg         rd = 1'b0;
   reg         we = 1'b0;
   reg  [31:0] wd = 32'h0;
   reg  [3:0]  be = 4'hf;
   wire [31:0] rdata;
   wire        waitreq, irq, pa, pb, pi;
   integer     errors = 0, num_checks = 0, cyc = 0;
   reg  [31:0] v;
   always #25 mclk = ~mclk;
   qei_enc_model enc (.mclk(mclk), .phase_a(pa), .phase_b(pb),
      .index_pulse(pi));
   qei_core #(.W(32)) DUT (.mclk(mclk), .rst(rst), .phase_a_input(pa),
      .phase_b_input(pb), .index_input(pi), .cpu_halt(cpu_halt),
      .avs_address(adr), .avs_read(rd), .avs_write(we),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(waitreq), .irq(irq));
   task tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   task chk(input string n, input [31:0] e, input [31:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input [3:0] a, input [31:0] d);
      @(posedge mclk);
      adr <= a;
      wd <= d;
      we <= w;
      rd <= ~w;
      do @(posedge mclk); while (waitreq !== 1'b0);
      v = rdata;
      we <= 1'b0;
      rd <= 1'b0;
   endtask
   task wr(input [3:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task ck(input [3:0] a, input string n, input [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, v);
   endtask
   task steps(input logic fw, input integer n);
      repeat (n) enc.step(fw);
   endtask
   task t_reset;
      ck(4'h0, "ctl", 0);
      ck(4'h9, "raw", 0);
      ck(4'hc, "unmapped", 0);
   endtask
   task t_quad;
      be <= 4'h1;
      wr(4'h3, 32'hffff_ff07);
      be <= 4'hf;
      ck(4'h3, "max", 7);
      wr(4'h0, 32'h9);
      steps(1, 4);
      ck(4'h2, "pos up", 4);
      bus(1'b0, 4'h9, 0);
      chk("raw no dir", 0, v & 4);
      steps(0, 5);
      ck(4'h2, "pos wrap", 7);
      steps(1, 1);
      ck(4'h2, "pos max", 0);
      bus(1'b0, 4'h9, 0);
      chk("raw dir", 4, v & 4);
      ck(4'ha, "masked", 0);
      wr(4'ha, 15);
      bus(1'b0, 4'h9, 0);
      chk("raw clr", 0, v & 4);
   endtask
   task t_cap;
      wr(4'h0, 32'h1);
      wr(4'h2, 0);
      steps(1, 4);
      ck(4'h2, "pos a only", 2);
      wr(4'h0, 32'hb);
      wr(4'h2, 4);
      steps(1, 2);
      ck(4'h2, "pos swap", 2);
      wr(4'h0, 32'h1009);
      cpu_halt <= 1'b1;
      steps(1, 2);
      ck(4'h2, "pos stall", 2);
      cpu_halt <= 1'b0;
      steps(1, 1);
      ck(4'h2, "pos run", 3);
      wr(4'h0, 32'h209);
      wr(4'h2, 4);
      steps(1, 1);
      ck(4'h2, "pos inv a", 3);
   endtask
   task t_clkdir;
      wr(4'h0, 32'h5);
      enc.mv(0, 0, 0);
      wr(4'h2, 3);
      wr(4'ha, 15);
      enc.mv(1, 0, 0);
      ck(4'h2, "step up", 4);
      bus(1'b0, 4'h9, 0);
      chk("clk dir flip", 4, v & 4);
      wr(4'ha, 15);
      enc.mv(0, 1, 0);
      enc.mv(1, 1, 0);
      ck(4'h2, "step down", 3);
      bus(1'b0, 4'h1, 0);
      chk("stat dir", 2, v & 2);
      wr(4'ha, 15);
      enc.mv(0, 1, 0);
      enc.mv(1, 1, 0);
      bus(1'b0, 4'h9, 0);
      chk("clk dir same", 0, v & 4);
   endtask
   task t_index;
      wr(4'h0, 32'h19);
      wr(4'h2, 5);
      enc.mv(pa, pb, 1);
      enc.mv(pa, pb, 0);
      ck(4'h2, "pos index", 0);
      bus(1'b0, 4'h9, 0);
      chk("raw index", 1, v & 1);
      wr(4'h0, 32'h9);
      wr(4'h2, 5);
      enc.mv(pa, pb, 1);
      enc.mv(pa, pb, 0);
      enc.mv(~pa, ~pb, 0);
      ck(4'h2, "pos kept", 5);
      bus(1'b0, 4'h9, 0);
      chk("raw error", 8, v & 8);
   endtask
   task t_vel;
      integer d;
      wr(4'h0, 32'h20);
      ck(4'h0, "vel alone", 0);
      wr(4'h4, 999);
      ck(4'h4, "load", 999);
      ck(4'h5, "timer idle", 999);
      wr(4'h8, 2);
      ck(4'h8, "mask", 2);
      for (d = 0; d < 4; d = d + 1) begin
         wr(4'h0, 32'h9);
         wr(4'ha, 15);
         wr(4'h0, 32'h29 | (d << 6));
         steps(1, 8);
         ck(4'h6, "accum", 8 >> d);
         do bus(1'b0, 4'h9, 0); while (v[1] !== 1'b1);
         @(negedge mclk);
         chk("irq on", 1, irq);
         ck(4'h7, "speed", 8 >> d);
         ck(4'h6, "accum clr", 0);
         wr(4'ha, 15);
         @(negedge mclk);
         chk("irq off", 0, irq);
      end
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_quad;
      t_cap;
      t_clkdir;
      t_index;
      t_vel;
      tally_and_finish;
   end
endmodule // testbench
